// [hdl/spc_config_port.v]
// Purpose: Serial control port with interface configuration registers
// Assumes: Serial clock idles low, data sampled on its rising edge
// Notes: Frame = 16-bit instruction (read flag, 15-bit address), then bytes
//
// Operation
// - Upper four bits mirror lower four bits
// - Four-wire bit set selects separate output line
// - Streaming address steps up or down
// - Bit-order control sets LSB or MSB first
// - Main soft reset pulses, then clears itself
// - Second soft reset pulses, then clears itself
// - Third soft reset clears itself after pulse
`timescale 1ns/1ns
`default_nettype none
`include "spc_consts.vh"

module spc_config_port (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Serial port pins
    input wire sclk,
    input wire cs_n,
    input wire sdio_in,
    output reg sdio_out,
    output wire sdio_oe,
    output reg sdo_out,
    output wire sdo_oe,
    // Soft reset lines
    output wire main_reset_line,
    output wire second_reset_line,
    output wire third_reset_line,
    // Configuration to the device
    output wire one_instruction,
    output wire select_stall,
    output wire [1:0] system_power_mode
);

    // ************************************************
    // Functions
    // ************************************************
    function [7:0] rev8;
        input [7:0] v;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                rev8[i] = v[7 - i];
            end
        end
    endfunction

    function [15:0] rev16;
        input [15:0] v;
        integer i;
        begin
            for (i = 0; i < 16; i = i + 1) begin
                rev16[i] = v[15 - i];
            end
        end
    endfunction

    function [7:0] reg_read;
        input [14:0] a;
        input [3:0] ca;
        input [7:1] cb;
        input [7:0] dc;
        begin
            case (a)
                `SPC_OFS_CFG_A: reg_read = {ca[0], ca[1], ca[2], ca[3], ca};
                `SPC_OFS_CFG_B: reg_read = {cb, 1'b0};
                `SPC_OFS_DEV_CFG: reg_read = dc;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    // ************************************************
    // Pin synchronisers
    // ************************************************
    reg sclk_m_ff, sclk_s_ff, sclk_d_ff;
    reg cs_m_ff, cs_s_ff;
    reg sdi_m_ff, sdi_s_ff;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_m_ff <= 1'b0;
            sclk_s_ff <= 1'b0;
            sclk_d_ff <= 1'b0;
            cs_m_ff <= 1'b1;
            cs_s_ff <= 1'b1;
            sdi_m_ff <= 1'b0;
            sdi_s_ff <= 1'b0;
        end else begin
            sclk_m_ff <= sclk;
            sclk_s_ff <= sclk_m_ff;
            sclk_d_ff <= sclk_s_ff;
            cs_m_ff <= cs_n;
            cs_s_ff <= cs_m_ff;
            sdi_m_ff <= sdio_in;
            sdi_s_ff <= sdi_m_ff;
        end
    end

    wire sclk_rise = sclk_s_ff & ~sclk_d_ff & ~cs_s_ff;
    wire sclk_fall = ~sclk_s_ff & sclk_d_ff & ~cs_s_ff;

    // ************************************************
    // Registers
    // ************************************************
    reg [3:0] cfga_ff;
    reg [7:1] cfgb_ff;
    reg [7:0] devcfg_ff;

    wire low_bit_first = cfga_ff[`SPC_A_LOW_FIRST];
    wire addr_step_up = cfga_ff[`SPC_A_ADDR_UP];
    wire four_wire_enable = cfga_ff[`SPC_A_FOUR_WIRE];

    // ************************************************
    // Frame engine
    // ************************************************
    reg [15:0] sh_ff;
    reg [3:0] bit_cnt_ff;
    reg [2:0] dat_cnt_ff;
    reg in_data_ff;
    reg rd_ff;
    reg [14:0] addr_ff;
    reg [7:0] tx_ff;

    wire [15:0] sh_now = {sh_ff[14:0], sdi_s_ff};
    wire [15:0] instr_word = low_bit_first ? rev16(sh_now) : sh_now;
    wire [7:0] rx_byte = low_bit_first ? rev8(sh_now[7:0]) : sh_now[7:0];
    wire [14:0] addr_next = addr_step_up ? addr_ff + 15'h0001 : addr_ff - 15'h0001;
    wire byte_end = sclk_rise & in_data_ff & (dat_cnt_ff == `SPC_BYTE_LAST);
    wire wr_en = byte_end & ~rd_ff;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_ff <= 16'h0000;
            bit_cnt_ff <= 4'h0;
            dat_cnt_ff <= 3'h0;
            in_data_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 15'h0000;
            tx_ff <= 8'h00;
        end else if (cs_s_ff) begin
            bit_cnt_ff <= 4'h0;
            dat_cnt_ff <= 3'h0;
            in_data_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else if (sclk_rise) begin
            sh_ff <= sh_now;
            if (!in_data_ff) begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                if (bit_cnt_ff == `SPC_INSTR_LAST) begin
                    in_data_ff <= 1'b1;
                    rd_ff <= instr_word[15];
                    addr_ff <= instr_word[14:0];
                    tx_ff <= reg_read(instr_word[14:0], cfga_ff, cfgb_ff, devcfg_ff);
                    dat_cnt_ff <= 3'h0;
                end
            end else begin
                dat_cnt_ff <= dat_cnt_ff + 3'h1;
                if (dat_cnt_ff == `SPC_BYTE_LAST) begin
                    addr_ff <= addr_next;
                    tx_ff <= reg_read(addr_next, cfga_ff, cfgb_ff, devcfg_ff);
                end
            end
        end
    end

    // ************************************************
    // Read data output
    // ************************************************
    // output bit order
    wire tx_bit = low_bit_first ? tx_ff[dat_cnt_ff] : tx_ff[3'h7 - dat_cnt_ff];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdio_out <= 1'b0;
            sdo_out <= 1'b0;
        end else if (sclk_fall & in_data_ff & rd_ff) begin
            sdio_out <= tx_bit;
            sdo_out <= tx_bit;
        end
    end

    assign sdio_oe = ~cs_s_ff & in_data_ff & rd_ff & ~four_wire_enable;
    assign sdo_oe = ~cs_s_ff & in_data_ff & rd_ff & four_wire_enable;

    // ************************************************
    // Register writes and self-clearing resets
    // ************************************************
    wire main_done, second_done, third_done;
    wire wr_a = wr_en & (addr_ff == `SPC_OFS_CFG_A);
    wire wr_b = wr_en & (addr_ff == `SPC_OFS_CFG_B);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfga_ff <= `SPC_RST_CFG_A;
            cfgb_ff <= `SPC_RST_CFG_B;
            devcfg_ff <= `SPC_RST_DEV_CFG;
        end else begin
            if (wr_a) begin
                cfga_ff[3:1] <= rx_byte[3:1];
            end
            if (wr_b) begin
                cfgb_ff[7:3] <= rx_byte[7:3];
            end
            if (wr_en & (addr_ff == `SPC_OFS_DEV_CFG)) begin
                devcfg_ff <= rx_byte;
            end
            if (wr_a & rx_byte[`SPC_A_MAIN_RST]) begin
                cfga_ff[`SPC_A_MAIN_RST] <= 1'b1;
            end else if (main_done) begin
                cfga_ff[`SPC_A_MAIN_RST] <= 1'b0;
            end
            if (wr_b & rx_byte[`SPC_B_SECOND_RST]) begin
                cfgb_ff[`SPC_B_SECOND_RST] <= 1'b1;
            end else if (second_done) begin
                cfgb_ff[`SPC_B_SECOND_RST] <= 1'b0;
            end
            if (wr_b & rx_byte[`SPC_B_THIRD_RST]) begin
                cfgb_ff[`SPC_B_THIRD_RST] <= 1'b1;
            end else if (third_done) begin
                cfgb_ff[`SPC_B_THIRD_RST] <= 1'b0;
            end
        end
    end

    spc_reset_pulse u_main_rst (
        .clk(clk),
        .rst_n(rst_n),
        .req(cfga_ff[`SPC_A_MAIN_RST]),
        .line(main_reset_line),
        .done(main_done)
    );

    spc_reset_pulse u_second_rst (
        .clk(clk),
        .rst_n(rst_n),
        .req(cfgb_ff[`SPC_B_SECOND_RST]),
        .line(second_reset_line),
        .done(second_done)
    );

    spc_reset_pulse u_third_rst (
        .clk(clk),
        .rst_n(rst_n),
        .req(cfgb_ff[`SPC_B_THIRD_RST]),
        .line(third_reset_line),
        .done(third_done)
    );

    assign one_instruction = cfgb_ff[`SPC_B_ONE_INSTR];
    assign select_stall = cfgb_ff[`SPC_B_STALL];
    assign system_power_mode = devcfg_ff[1:0];

endmodule // spc_config_port

`default_nettype wire

// [hdl/spc_consts.vh]
// Purpose: Constants of the serial configuration port
// Assumes: 125 MHz system clock
// Notes: Offsets, bit positions, reset values and timing counts
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// ************************************************
// Register offsets
// ************************************************
`define SPC_OFS_CFG_A 15'h0000
`define SPC_OFS_CFG_B 15'h0001
`define SPC_OFS_DEV_CFG 15'h0002

// ************************************************
// Field positions
// ************************************************
`define SPC_A_MAIN_RST 0
`define SPC_A_LOW_FIRST 1
`define SPC_A_ADDR_UP 2
`define SPC_A_FOUR_WIRE 3
`define SPC_B_THIRD_RST 1
`define SPC_B_SECOND_RST 2
`define SPC_B_STALL 6
`define SPC_B_ONE_INSTR 7

// ************************************************
// Reset values
// ************************************************
`define SPC_RST_CFG_A 4'h0
`define SPC_RST_CFG_B 7'h00
`define SPC_RST_DEV_CFG 8'h00

// ************************************************
// Frame and timing
// ************************************************
`define SPC_INSTR_LAST 4'hf
`define SPC_BYTE_LAST 3'h7
`define SPC_CLK_NS 8
`define SPC_SRST_NS 32
`define SPC_SRST_CYC ((`SPC_SRST_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)

`endif

// [hdl/spc_reset_pulse.v]
// Purpose: Drives one soft reset line for a fixed time on request
// Assumes: Request is a register bit that stays set until done
// Notes: done is a one-cycle pulse that clears the request bit
`timescale 1ns/1ns
`default_nettype none
`include "spc_consts.vh"

module spc_reset_pulse (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Request and result
    input wire req,
    output wire line,
    output wire done
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_PULSE = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;
    localparam integer PULSE_CYC = `SPC_SRST_CYC;
    localparam [7:0] PULSE_LAST = PULSE_CYC[7:0] - 8'h01;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [7:0] cnt_ff;
    reg [7:0] nxt_cnt;

    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req) begin
                    nxt_state = ST_PULSE;
                    nxt_cnt = 8'h00;
                end
            end
            ST_PULSE: begin
                if (cnt_ff == PULSE_LAST) begin
                    nxt_state = ST_DONE;
                end else begin
                    nxt_cnt = cnt_ff + 8'h01;
                end
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    assign line = (state_ff == ST_PULSE);
    assign done = (state_ff == ST_DONE);

endmodule // spc_reset_pulse

`default_nettype wire

// [tb/spc_config_port_asserts.sv]
// Purpose: Port checks of the serial config port
// Assumes: Soft reset pulse of 4 clk
// Notes: Bound to the design top
`timescale 1ns/1ns
`default_nettype none
module spc_config_port_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins and outputs
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic sdo_oe,
    input wire logic main_reset_line,
    input wire logic second_reset_line,
    input wire logic third_reset_line,
    input wire logic one_instruction,
    input wire logic [1:0] system_power_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_pulse(s);
        s [*4] ##1 !s;
    endsequence
    a_oe_one_line: assert property (!(sdio_oe && sdo_oe))
        else $error("both outputs enabled");
    a_oe_idle_off: assert property (cs_n [*5] |-> !sdio_oe && !sdo_oe)
        else $error("output enabled while idle");
    a_oe_rise_frame: assert property ($rose(sdio_oe || sdo_oe) |-> !cs_n)
        else $error("output enabled outside frame");
    a_out_hold_high: assert property (sclk [*5] |-> $stable(sdio_out))
        else $error("read bit moved while sclk high");
    a_pulse_main: assert property ($rose(main_reset_line) |-> s_pulse(main_reset_line))
        else $error("main reset pulse length");
    a_pulse_second: assert property ($rose(second_reset_line) |-> s_pulse(second_reset_line))
        else $error("second reset pulse length");
    a_pulse_third: assert property ($rose(third_reset_line) |-> s_pulse(third_reset_line))
        else $error("third reset pulse length");
    a_cfg_hold_idle: assert property (cs_n [*8] |-> $stable(one_instruction) && $stable(system_power_mode))
        else $error("config moved while idle");
endmodule // spc_config_port_asserts
bind spc_config_port spc_config_port_asserts spc_config_port_asserts_inst (.clk, .rst_n, .sclk, .cs_n,
    .sdio_out, .sdio_oe, .sdo_oe, .main_reset_line, .second_reset_line, .third_reset_line, .one_instruction,
    .system_power_mode);
`default_nettype wire

// [tb/spc_host_model.sv]
// Purpose: Serial host that drives frames into the config port
// Assumes: Mode 0, sclk idles low, 80 ns period, signals moved 1 ns after clk
// Notes: An undriven data line toggles every clk
`timescale 1ns/1ns
`default_nettype none
module spc_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic sclk,
    output logic cs_n,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    logic drv = 1'b1;
    logic bit_v = 1'b0;
    logic sdio_l = 1'b0;
    logic sdo_l = 1'b0;
    logic sdo_w;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // wire levels of both data lines
    assign sdio_in = sdio_oe ? sdio_out : (drv ? bit_v : ~sdio_l);
    assign sdo_w = sdo_oe ? sdo_out : ~sdo_l;
    always @(posedge clk) begin
        sdio_l <= sdio_in;
        sdo_l <= sdo_w;
    end
    task automatic tick(input logic b, input logic four, output logic s);
        bit_v = b;
        repeat (5) @(posedge clk);
        #1 sclk = 1'b1;
        s = four ? sdo_w : sdio_in;
        repeat (5) @(posedge clk);
        #1 sclk = 1'b0;
    endtask
    // instruction and bytes in the chosen bit order
    task automatic frame(input logic rd, input logic [14:0] a, input int n, input logic lsb, input logic four,
                         input logic [15:0] wd, output logic [15:0] rdat);
        logic [15:0] w;
        logic s;
        int k;
        int j;
        w = {rd, a};
        rdat = 16'h0000;
        @(posedge clk);
        #1 cs_n = 1'b0;
        for (k = 0; k < 16; k++) tick(w[lsb ? k : 15 - k], four, s);
        drv = !rd || four;
        for (k = 0; k < 8 * n; k++) begin
            j = 8 * (k / 8) + (lsb ? k % 8 : 7 - k % 8);
            tick(wd[j], four, s);
            rdat[j] = s;
        end
        repeat (5) @(posedge clk);
        #1 cs_n = 1'b1;
        drv = 1'b1;
        repeat (5) @(posedge clk);
    endtask
endmodule // spc_host_model
`default_nettype wire

// [tb/test_spc_config_port.sv]
// Purpose: Register tests of the serial config port
// Assumes: Host model makes every frame
// Notes: Expected bytes worked out by hand
`timescale 1ns/1ns
`default_nettype none
`include "spc_consts.vh"
module test_spc_config_port;
    logic clk;
    logic rst_n;
    wire logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, sdo_out, sdo_oe;
    wire logic main_reset_line, second_reset_line, third_reset_line, one_instruction, select_stall;
    wire logic [1:0] system_power_mode;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int k;
    int cnt;
    logic [15:0] rd;
    spc_config_port spc_config_port_inst (.clk, .rst_n, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe, .sdo_out,
        .sdo_oe, .main_reset_line, .second_reset_line, .third_reset_line, .one_instruction, .select_stall,
        .system_power_mode);
    spc_host_model spc_host_model_inst (.clk, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe, .sdo_out, .sdo_oe);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [15:0] d, input int n, input logic lsb);
        spc_host_model_inst.frame(1'b0, a, n, lsb, 1'b0, d, rd);
    endtask
    task automatic rdc(input logic [14:0] a, input logic [15:0] exp, input int n, input logic lsb, input logic four);
        spc_host_model_inst.frame(1'b1, a, n, lsb, four, 16'h0000, rd);
        chk("read byte 0", exp[7:0], rd[7:0]);
        if (n > 1)
            chk("read byte 1", exp[15:8], rd[15:8]);
    endtask
    task automatic report_and_stop();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        for (k = 0; k < 3; k++) rdc(15'(k), 16'h0000, 1, 0, 0);
        wr(15'h0010, 16'h00ff, 1, 0);
        rdc(15'h0010, 16'h0000, 1, 0, 0);
        wr(`SPC_OFS_CFG_A, 16'h000c, 1, 0);
        rdc(`SPC_OFS_CFG_A, 16'h003c, 1, 0, 1);
        wr(`SPC_OFS_CFG_A, 16'h00f4, 1, 0);
        rdc(`SPC_OFS_CFG_A, 16'h0024, 1, 0, 0);
        wr(`SPC_OFS_CFG_B, 16'h03c0, 2, 0);
        chk("config outputs", 8'h0f, {4'h0, one_instruction, select_stall, system_power_mode});
        rdc(`SPC_OFS_CFG_B, 16'h03c0, 2, 0, 0);
        wr(`SPC_OFS_CFG_A, 16'h0000, 1, 0);
        wr(`SPC_OFS_DEV_CFG, 16'h4001, 2, 0);
        rdc(`SPC_OFS_DEV_CFG, 16'h4001, 2, 0, 0);
        wr(`SPC_OFS_CFG_A, 16'h0002, 1, 0);
        rdc(`SPC_OFS_CFG_A, 16'h0042, 1, 1, 0);
        wr(`SPC_OFS_DEV_CFG, 16'h0002, 1, 1);
        chk("power mode", 8'h02, {6'h00, system_power_mode});
        wr(`SPC_OFS_CFG_A, 16'h0000, 1, 1);
        for (k = 0; k < 3; k++) begin
            cnt = 0;
            fork
                wr(k > 0 ? `SPC_OFS_CFG_B : `SPC_OFS_CFG_A, k == 0 ? 16'h0001 : (k == 1 ? 16'h0004 : 16'h0002), 1, 0);
                repeat (300) begin
                    @(posedge clk);
                    #1 cnt += (k == 0) ? main_reset_line : ((k == 1) ? second_reset_line : third_reset_line);
                end
            join
            chk("pulse length", 8'(`SPC_SRST_CYC), 8'(cnt));
            rdc(k > 0 ? `SPC_OFS_CFG_B : `SPC_OFS_CFG_A, 16'h0000, 1, 0, 0);
        end
        report_and_stop();
    end
endmodule // test_spc_config_port
`default_nettype wire
